// [rsd_pkg.sv]
// Constants and payload type for the decoder output and status block
package rsd_pkg;
  // Stream widths
  localparam int SYM_W  = 8;
  localparam int CH_W   = 2;
  localparam int CH_NUM = 4;
  localparam int CHK_W  = 5;
  localparam int SCNT_W = 8;
  localparam int BCNT_W = 11;
  localparam int CWC_W  = 16;

  // Codeword geometry limits fixed at build time
  localparam logic [CHK_W-1:0] R_MAX = 5'h10;
  localparam logic [SYM_W-1:0] N_MAX = 8'hff;
  localparam logic [SYM_W-1:0] N_MIN = 8'h11;

  // Register byte offsets
  localparam logic [7:0] OFS_NUM_CHECK = 8'h00;
  localparam logic [7:0] OFS_NUMN      = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] OFS_CW_COUNT  = 8'h10;

  // Interrupt bit positions and register reset values
  localparam int IRQ_W        = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam logic [CHK_W-1:0] NUM_CHECK_RST = R_MAX;
  localparam logic [SYM_W-1:0] NUMN_RST      = N_MAX;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST  = 2'h0;

  // One output beat with its status
  typedef struct packed {
    logic [SYM_W-1:0]  data;
    logic [CH_W-1:0]   chan;
    logic              first;
    logic              last;
    logic              fail;
    logic [SYM_W-1:0]  corr;
    logic [SCNT_W-1:0] nsym;
    logic [BCNT_W-1:0] nbit;
    logic [BCNT_W-1:0] n10;
    logic [BCNT_W-1:0] n01;
  } rsd_word_s;
endpackage

// [rsd_out_status.sv]
// Decoder output stream, configuration and status counters behind Wishbone
`timescale 1ns/1ps
module rsd_out_status
  import rsd_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // Input stream from the decoding core
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [SYM_W-1:0]  in_data,
  input  wire logic [CH_W-1:0]   in_channel,
  input  wire logic              in_sop,
  input  wire logic              in_eop,
  input  wire logic [SYM_W-1:0]  in_corr,
  input  wire logic              in_fail,
  // Output stream
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [SYM_W-1:0]       out_data,
  output logic [CH_W-1:0]        out_channel,
  output logic                   result_codeword_first,
  output logic                   out_codeword_last,
  output logic                   out_error,
  // Per-symbol and per-codeword status
  output logic [SYM_W-1:0]       status_error_value,
  output logic [SCNT_W-1:0]      status_num_error_symbol,
  output logic [BCNT_W-1:0]      status_num_error_bit,
  output logic [BCNT_W-1:0]      split_bit_flip_counts_one_to_zero,
  output logic [BCNT_W-1:0]      split_bit_flip_counts_zero_to_one,
  // Configuration values
  output logic [CHK_W-1:0]       cfg_num_check,
  output logic [SYM_W-1:0]       cfg_numn,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // Interrupt
  output logic                   irq
);

  // Number of set bits in a symbol, widened to a bit counter
  // Unrolled adder chain of SYM_W bits; cheap at this symbol width
  function automatic logic [BCNT_W-1:0] ones(input logic [SYM_W-1:0] v);
    logic [BCNT_W-1:0] cnt;
    cnt = '0;
    for (int i = 0; i < SYM_W; i++)
    begin
      cnt = cnt + {{(BCNT_W-1){1'b0}}, v[i]};
    end
    return cnt;
  endfunction

  // Clamp a requested value into [lo, hi]
  // Used for the codeword length, whose legal range has two ends
  function automatic logic [SYM_W-1:0] clamp(input logic [SYM_W-1:0] v, input logic [SYM_W-1:0] lo,
                                             input logic [SYM_W-1:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Per-channel running totals, indexed by channel number
  // Length is counted too, to catch a codeword that disagrees with the setting
  logic [SCNT_W-1:0] acc_sym [CH_NUM];
  logic [BCNT_W-1:0] acc_bit [CH_NUM];
  logic [BCNT_W-1:0] acc_10  [CH_NUM];
  logic [BCNT_W-1:0] acc_01  [CH_NUM];
  logic [SYM_W-1:0]  acc_len [CH_NUM];

  // Two-beat output stage: head register plus a skid slot.
  // in_ready is registered, so a beat may already be in flight when the
  // output stalls; the skid slot holds it until the head register frees.
  // After the first edge in_ready is always the inverse of skid_valid.
  rsd_word_s         out_word;
  rsd_word_s         skid_word;
  logic              skid_valid;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [CWC_W-1:0]  cw_count;

  // Input beat decode.
  // A first marker restarts the channel's totals in the same cycle, so a
  // codeword cut short on one channel never leaks counts into the next one.
  // Totals wrap at their width; a codeword beyond 255 symbols miscounts.
  wire               take      = in_valid & in_ready;
  wire [SYM_W-1:0]   flips     = in_corr;
  wire [SCNT_W-1:0]  base_sym  = in_sop ? '0 : acc_sym[in_channel];
  wire [BCNT_W-1:0]  base_bit  = in_sop ? '0 : acc_bit[in_channel];
  wire [BCNT_W-1:0]  base_10   = in_sop ? '0 : acc_10[in_channel];
  wire [BCNT_W-1:0]  base_01   = in_sop ? '0 : acc_01[in_channel];
  wire [SYM_W-1:0]   base_len  = in_sop ? '0 : acc_len[in_channel];
  wire [SCNT_W-1:0]  new_sym   = base_sym + {{(SCNT_W-1){1'b0}}, |flips};
  wire [BCNT_W-1:0]  new_bit   = base_bit + ones(flips);
  wire [BCNT_W-1:0]  new_10    = base_10 + ones(flips & in_data);
  wire [BCNT_W-1:0]  new_01    = base_01 + ones(flips & ~in_data);
  wire [SYM_W-1:0]   new_len   = base_len + 8'h01;
  // A codeword whose length disagrees with the configured length cannot be trusted
  wire               len_bad   = (new_len != cfg_numn);
  wire               new_fail  = in_eop & (in_fail | len_bad);
  wire rsd_word_s    in_word   = '{data: in_data ^ in_corr, chan: in_channel, first: in_sop, last: in_eop,
                                   fail: new_fail, corr: in_corr, nsym: new_sym, nbit: new_bit,
                                   n10: new_10, n01: new_01};

  // Output handshake terms; the head may load while empty even with ready
  // low, which keeps latency at one cycle without breaking the hold rule
  wire               out_free   = ~out_valid | out_ready;
  wire               next_skid  = out_free ? 1'b0 : (skid_valid | take);
  wire               out_done   = out_valid & out_ready & out_word.last;

  // Outputs straight from the head register
  // No logic between the head register and the pins keeps output timing clean
  assign out_data                          = out_word.data;
  assign out_channel                       = out_word.chan;
  assign result_codeword_first             = out_word.first;
  assign out_codeword_last                 = out_word.last;
  assign out_error                         = out_word.fail;
  assign status_error_value                = out_word.corr;
  assign status_num_error_symbol           = out_word.nsym;
  assign status_num_error_bit              = out_word.nbit;
  assign split_bit_flip_counts_one_to_zero = out_word.n10;
  assign split_bit_flip_counts_zero_to_one = out_word.n01;

  // Running totals; first marker restarts a channel's codeword.
  // One set per channel so interleaved codewords keep separate counts.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int c = 0; c < CH_NUM; c++)
      begin
        acc_sym[c] <= '0;
        acc_bit[c] <= '0;
        acc_10[c]  <= '0;
        acc_01[c]  <= '0;
        acc_len[c] <= '0;
      end
    end
    else if (take)
    begin
      acc_sym[in_channel] <= new_sym;
      acc_bit[in_channel] <= new_bit;
      acc_10[in_channel]  <= new_10;
      acc_01[in_channel]  <= new_01;
      acc_len[in_channel] <= new_len;
    end
  end

  // Head and skid registers; skid keeps full rate with a registered ready
  // A skid beat always leaves before any new input beat, which keeps order.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_word   <= '0;
      skid_word  <= '0;
      out_valid  <= 1'b0;
      skid_valid <= 1'b0;
      in_ready   <= 1'b0;
    end
    else
    begin
      in_ready   <= ~next_skid;
      skid_valid <= next_skid;
      if (out_free)
      begin
        if (skid_valid)
        begin
          out_word  <= skid_word;
          out_valid <= 1'b1;
        end
        else if (take)
        begin
          out_word  <= in_word;
          out_valid <= 1'b1;
        end
        else
        begin
          out_valid <= 1'b0;
        end
      end
      else if (take)
      begin
        skid_word <= in_word;
      end
    end
  end

  // Register decode. Map, one 32-bit word each, fields in the low byte except the 16-bit count at 0x10:
  //   0x00 check-symbol count, clamped to the build maximum
  //   0x04 codeword length, clamped to the legal range
  //   0x08 event status, write one to clear
  //   0x0c event mask, same layout as status
  //   0x10 completed codeword count, read only
  // Only byte lane 0 gates writes because no field reaches past it.
  wire               wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire               wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
  wire               wr_chk   = wb_wr & (wb_adr_i == OFS_NUM_CHECK);
  wire               wr_numn  = wb_wr & (wb_adr_i == OFS_NUMN);
  wire               wr_stat  = wb_wr & (wb_adr_i == OFS_IRQ_STAT);
  wire               wr_mask  = wb_wr & (wb_adr_i == OFS_IRQ_MASK);
  wire [CHK_W-1:0]   req_chk  = (wb_dat_i[7:0] > {3'h0, R_MAX}) ? R_MAX : wb_dat_i[CHK_W-1:0];
  wire [IRQ_W-1:0]   irq_set  = {out_done & out_word.fail, out_done};
  // Set wins over a write-one clear in the same cycle
  wire [IRQ_W-1:0]   next_stat = (irq_stat & ~(wr_stat ? wb_dat_i[IRQ_W-1:0] : '0)) | irq_set;
  wire [31:0]        rd_data  = (wb_adr_i == OFS_NUM_CHECK) ? {27'h0, cfg_num_check} :
                                (wb_adr_i == OFS_NUMN)      ? {24'h0, cfg_numn} :
                                (wb_adr_i == OFS_IRQ_STAT)  ? {30'h0, irq_stat} :
                                (wb_adr_i == OFS_IRQ_MASK)  ? {30'h0, irq_mask} :
                                (wb_adr_i == OFS_CW_COUNT)  ? {16'h0, cw_count} : 32'h0;

  // Configuration registers, clamped on write.
  // Clamping rather than refusing keeps the read-back value legal at all
  // times, at the cost of software not seeing that its value was altered.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_num_check <= NUM_CHECK_RST;
      cfg_numn      <= NUMN_RST;
    end
    else
    begin
      if (wr_chk)
      begin
        cfg_num_check <= req_chk;
      end
      if (wr_numn)
      begin
        cfg_numn <= clamp(wb_dat_i[SYM_W-1:0], N_MIN, N_MAX);
      end
    end
  end

  // Bus answer one cycle after the request; unmapped reads return zero.
  // A write lands at the request edge, the same edge that raises ack, so software
  // that reads back straight after the ack always sees the new value.
  // Ack is masked from the request so it is a one-cycle pulse; a held strobe is answered every second cycle.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0;
    end
  end

  // Interrupt status, mask, line and codeword counter.
  // The line is built from next status and the incoming mask, so it follows
  // a mask or clear write in the same cycle as the registers themselves.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_stat <= '0;
      irq_mask <= IRQ_MASK_RST;
      irq      <= 1'b0;
      cw_count <= '0;
    end
    else
    begin
      irq_stat <= next_stat;
      irq      <= |(next_stat & (wr_mask ? wb_dat_i[IRQ_W-1:0] : irq_mask));
      if (wr_mask)
      begin
        irq_mask <= wb_dat_i[IRQ_W-1:0];
      end
      if (out_done)
      begin
        cw_count <= cw_count + 16'h0001; // Wraps; software takes differences
      end
    end
  end

endmodule

// [rsd_sink_model.sv]
// Downstream consumer model that paces the output ready line
`timescale 1ns/1ps
module rsd_sink_model
  import rsd_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Pacing control and handshake
  input  wire logic slow,
  output logic      out_ready
);
  logic [1:0] ph;

  // Slow mode takes one beat in three so the skid slot fills
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      ph        <= 2'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      ph        <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      out_ready <= !slow || ph == 2'h2;
    end
endmodule

// [rsd_out_status_asserts.sv]
// Concurrent checks on the output stream and bus handshake
`timescale 1ns/1ps
module rsd_out_status_chk
  import rsd_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst_b,
  // Input stream
  input wire logic              in_valid,
  input wire logic              in_ready,
  input wire logic [SYM_W-1:0]  in_data,
  input wire logic [SYM_W-1:0]  in_corr,
  input wire logic [CH_W-1:0]   in_channel,
  input wire logic              in_sop,
  input wire logic              in_eop,
  // Output stream and status
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire logic [SYM_W-1:0]  out_data,
  input wire logic [CH_W-1:0]   out_channel,
  input wire logic              result_codeword_first,
  input wire logic              out_codeword_last,
  input wire logic [SYM_W-1:0]  status_error_value,
  input wire logic [BCNT_W-1:0] status_num_error_bit,
  input wire logic [BCNT_W-1:0] split_bit_flip_counts_one_to_zero,
  input wire logic [BCNT_W-1:0] split_bit_flip_counts_zero_to_one,
  input wire logic [CHK_W-1:0]  cfg_num_check,
  input wire logic [SYM_W-1:0]  cfg_numn,
  // Bus handshake
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Beat taken while output stage is empty, so no skid beat overtakes it
  sequence s_take_empty;
    in_valid && in_ready && !out_valid;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_fill_next: assert property (s_take_empty |=> out_valid)
    else $error("taken beat did not appear");
  a_data_fixed: assert property (s_take_empty |=> out_data == ($past(in_data) ^ $past(in_corr))
    && status_error_value == $past(in_corr)) else $error("corrected symbol wrong");
  a_marks_copy: assert property (s_take_empty |=> result_codeword_first == $past(in_sop)
    && out_codeword_last == $past(in_eop)) else $error("codeword markers wrong");
  a_chan_copy: assert property (s_take_empty |=> out_channel == $past(in_channel))
    else $error("channel wrong");
  a_stall_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_codeword_last) && $stable(result_codeword_first) && $stable(out_channel))
    else $error("stalled beat changed");
  a_idle_low: assert property (!out_valid && !(in_valid && in_ready) |=> !out_valid)
    else $error("valid without a beat");
  a_split_sum: assert property (out_valid && out_codeword_last |-> 12'(split_bit_flip_counts_one_to_zero)
    + 12'(split_bit_flip_counts_zero_to_one) == 12'(status_num_error_bit)) else $error("bit counts disagree");
  a_cfg_range: assert property (cfg_num_check <= R_MAX && cfg_numn >= N_MIN)
    else $error("config out of range");
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_once)
    else $error("ack not a single pulse");
endmodule

bind rsd_out_status rsd_out_status_chk u_chk (.core_clk, .rst_b, .in_valid, .in_ready, .in_data, .in_corr,
  .in_channel, .in_sop, .in_eop, .out_valid, .out_ready, .out_data, .out_channel, .result_codeword_first,
  .out_codeword_last, .status_error_value, .status_num_error_bit, .split_bit_flip_counts_one_to_zero,
  .split_bit_flip_counts_zero_to_one, .cfg_num_check, .cfg_numn, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// [testbench.sv]
// Self-checking bench for the decoder output and status block
`timescale 1ns/1ps
module testbench
  import rsd_pkg::*;
;
  logic        core_clk = 0, rst_b = 0, slow = 0, in_valid = 0, in_sop = 0, in_eop = 0, in_fail = 0;
  logic [7:0]  in_data = 0, in_corr = 0, wb_adr_i = 0, out_data, status_error_value, status_num_error_symbol;
  logic [1:0]  in_channel = 0, out_channel;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq, in_ready, out_valid, out_ready;
  logic        result_codeword_first, out_codeword_last, out_error;
  logic [3:0]  wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [4:0]  cfg_num_check;
  logic [7:0]  cfg_numn;
  logic [10:0] status_num_error_bit, split_bit_flip_counts_one_to_zero, split_bit_flip_counts_zero_to_one;
  logic [19:0] qb[$];
  logic [41:0] qc[$];
  int          errors = 0, n_tests = 0;

  rsd_out_status dut (.core_clk, .rst_b, .in_valid, .in_ready, .in_data, .in_channel, .in_sop, .in_eop,
    .in_corr, .in_fail, .out_valid, .out_ready, .out_data, .out_channel, .result_codeword_first,
    .out_codeword_last, .out_error, .status_error_value, .status_num_error_symbol, .status_num_error_bit,
    .split_bit_flip_counts_one_to_zero, .split_bit_flip_counts_zero_to_one, .cfg_num_check, .cfg_numn,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq);
  rsd_sink_model sink (.core_clk, .rst_b, .slow, .out_ready);

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  task automatic check(input logic [41:0] got, input logic [41:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Classic single bus cycle; read data lands in q
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h1;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // One codeword of len symbols, back to back; a length other than the set one is flagged
  task automatic cw(input logic [1:0] ch, input logic fail, input int len);
    logic [7:0]  d, c;
    logic [41:0] s;
    s = {fail || len != int'(N_MIN), 41'h0};
    @(posedge core_clk);
    for (int i = 0; i < len; i++)
    begin
      d = 8'(i * 37 + ch);
      c = (i % 4 == 0) ? 8'h00 : 8'(i * 3 + 1);
      qb.push_back({i == 0, i == len - 1, ch, c, d ^ c});
      s[40:33] += 8'(c != 0);
      s[32:22] += 11'($countones(c));
      s[21:11] += 11'($countones(c & d));
      s[10:0] += 11'($countones(c & ~d));
      in_valid   <= 1'b1;
      in_data    <= d;
      in_corr    <= c;
      in_channel <= ch;
      in_sop     <= i == 0;
      in_eop     <= i == len - 1;
      in_fail    <= fail && i == len - 1;
      do @(posedge core_clk); while (in_ready !== 1'b1);
    end
    qc.push_back(s);
    in_valid <= 1'b0;
  endtask

  // Output monitor; held beats are counted once, when taken
  always @(posedge core_clk)
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      check({result_codeword_first, out_codeword_last, out_channel, status_error_value, out_data},
        qb.pop_front());
      if (out_codeword_last !== 1'b0)
        check({out_error, status_num_error_symbol, status_num_error_bit, split_bit_flip_counts_one_to_zero,
          split_bit_flip_counts_zero_to_one}, qc.pop_front());
    end

  // Watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    #400000;
    errors++;
    conclude;
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    wb(0, OFS_NUM_CHECK, 0);
    check(q, R_MAX);
    wb(0, OFS_NUMN, 0);
    check(q, N_MAX);
    wb(1, OFS_NUM_CHECK, 32'h1f);
    wb(0, OFS_NUM_CHECK, 0);
    check(q, R_MAX);
    wb(1, OFS_NUM_CHECK, 32'h08);
    check(cfg_num_check, 5'h08);
    wb(1, OFS_NUMN, 32'h05);
    wb(0, OFS_NUMN, 0);
    check(q, N_MIN);
    check(cfg_numn, N_MIN);
    wb(0, 8'h20, 0);
    check(q, 32'h0);
    cw(2'h1, 1'b0, 17);
    slow <= 1'b1;
    cw(2'h2, 1'b1, 17);
    cw(2'h3, 1'b0, 17);
    cw(2'h0, 1'b0, 16);
    while (qb.size() != 0)
      @(posedge core_clk);
    check(irq, 1'b0);
    wb(0, OFS_IRQ_STAT, 0);
    check(q, 32'h3);
    wb(1, OFS_IRQ_MASK, 32'h3);
    @(posedge core_clk);
    check(irq, 1'b1);
    wb(1, OFS_IRQ_STAT, 32'h3);
    @(posedge core_clk);
    check(irq, 1'b0);
    wb(0, OFS_CW_COUNT, 0);
    check(q, 32'h4);
    conclude;
  end
endmodule
